/* hw/usbbsc_top.sv */
// Module: USB device global control, VBUS sensing, bus reset, address and suspend logic
`timescale 1ns/10ps
// How it works
// - session-valid follows the VBUS comparator (at or above 1.4V) and feeds status.
// - VBUS change flag sets on each rising or falling VBUS edge, sticky.
// - pull-up stays off while VBUS status reads clear.
// - pad regulator enable is bit 0 of regulator control, rest reserved.
// - clearing controller enable resets the controller, transceiver and clocks.
// - clock freeze bit 5 stops controller clocks; resume detection keeps working.
// - VBUS pad enable bit 4 stays writable with controller disabled.
// - control bit 0 gates VBUS change onto an interrupt request.
// - status reads bit1 one, bit0 VBUS, bits 7:2 zero.
// - VBUS change flag set by hardware, cleared by software writing zero.
// - reset freezes clock, sets detach, clears banks, pull-ups inactive.
// - speed pull-up only when detach clear and VBUS present.
// - endpoint reset clears state and flags, keeps toggle, config and enable.
// - SE0 for 2.5us is bus reset, disabling endpoints except control endpoint.
// - CPU-reset option makes bus reset pulse CPU reset, controller stays attached.
// - disabled endpoint held reset; packets unacknowledged until config accepted.
// - config accepted withheld when endpoint size exceeds dual-port memory.
// - clearing endpoint enable resets endpoint and toggle, keeps size and allocation.
// - address reads 00h default; answered address 00h while address-valid clear.
// - 3ms bus idle selects full speed for one cycle only and sets suspend flag.
// - wake flag on non-idle lines; each flag clears the other.
// - suspend puts pad idle; non-idle bus event reactivates it.
module usbbsc_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Pads
  input wire usbbsc_pkg::usbbsc_pads_s i_pads,
  // Endpoint side
  input wire logic [usbbsc_pkg::NUM_EP-1:0] i_ep_toggle_flip,
  output logic [usbbsc_pkg::NUM_EP-1:0] o_ep_reset,
  output logic [usbbsc_pkg::NUM_EP-1:0] o_ep_ack_ok,
  output logic [6:0] o_match_addr,
  // Pad and power control
  output logic o_regulator_on,
  output logic o_vbus_pad_on,
  output logic o_xcvr_on,
  output logic o_clk_run,
  output logic o_pad_active,
  output logic o_pullup_dp,
  output logic o_pullup_dm,
  output logic o_full_speed,
  output logic o_vbus_irq,
  output logic o_cpu_reset
);
  // Register state
  logic [7:0] pad_regulator_ctrl;
  logic [7:0] controller_ctrl;
  logic vbus_change_flag;
  logic detach, low_speed, cpu_reset_on_bus_reset;
  logic suspend_flag, wake_flag, bus_reset_flag, wake_irq_en;
  logic [2:0] endpoint_select;
  logic [6:0] device_address_field;
  logic address_valid;
  logic [usbbsc_pkg::NUM_EP-1:0] ep_en, ep_memory_reserve, ep_cfg_ok, ep_toggle;
  logic [usbbsc_pkg::NUM_EP-1:0] ep_rst_pulse;
  logic [2:0] ep_size [usbbsc_pkg::NUM_EP];
  logic ep_bank [usbbsc_pkg::NUM_EP];
  // Synchronisers: three stages, a change counts once stages two and three agree
  logic [2:0] vb_sync, dp_sync, dm_sync;
  logic vbus_state, dp_s, dm_s;
  logic enabled, frozen;
  logic [23:0] idle_cnt;
  logic [6:0] se0_cnt;
  logic bus_reset_now;
  logic [2:0] line;
  logic [2:0] line_q;
  logic wr_ctrl_hit;

  // Endpoint size in bytes: 8 << code, doubled for two banks; 12 bits so the
  // largest double-bank request cannot wrap round to a small value
  function automatic logic [11:0] ep_bytes(input logic [2:0] sz, input logic dbl);
    logic [11:0] b;
    b = 12'h008 << sz;
    ep_bytes = dbl ? (b << 1) : b;
  endfunction

  assign enabled = controller_ctrl[usbbsc_pkg::POS_CTRL_EN];
  assign frozen = controller_ctrl[usbbsc_pkg::POS_FRZ];
  assign wr_ctrl_hit = i_wr && (i_addr == usbbsc_pkg::REG_DEV_FLAGS);

  // Pad inputs cross into the clock domain; VBUS pad runs even when disabled
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      vb_sync <= 3'h0;
      dp_sync <= 3'h0;
      dm_sync <= 3'h0;
      vbus_state <= 1'b0;
      dp_s <= 1'b0;
      dm_s <= 1'b0;
    end else begin
      vb_sync <= {vb_sync[1:0], i_pads.vbus_valid & controller_ctrl[usbbsc_pkg::POS_VPAD]};
      dp_sync <= {dp_sync[1:0], i_pads.dp};
      dm_sync <= {dm_sync[1:0], i_pads.dm};
      if (vb_sync[1] == vb_sync[2]) vbus_state <= vb_sync[2];
      if (dp_sync[1] == dp_sync[2]) dp_s <= dp_sync[2];
      if (dm_sync[1] == dm_sync[2]) dm_s <= dm_sync[2];
    end
  end

  // Line state decode: J depends on the chosen speed
  always_comb begin
    if (!dp_s && !dm_s) line = usbbsc_pkg::LINE_SE0;
    else if (dp_s != low_speed) line = usbbsc_pkg::LINE_J;
    else line = usbbsc_pkg::LINE_K;
  end

  // Global control registers; regulator and pad enable stay live when disabled
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      pad_regulator_ctrl <= usbbsc_pkg::RST_ZERO;
      controller_ctrl <= usbbsc_pkg::RST_CTRL;
    end else if (i_wr && i_addr == usbbsc_pkg::REG_PAD_REG_CTRL) begin
      pad_regulator_ctrl <= {7'h00, i_wdata[usbbsc_pkg::POS_REG_EN]};
    end else if (i_wr && i_addr == usbbsc_pkg::REG_CTRL) begin
      controller_ctrl <= i_wdata & 8'hB1;
    end
  end

  // VBUS change flag: set wins over a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      vbus_change_flag <= 1'b0;
    end else if (vb_sync[2] != vbus_state && vb_sync[1] == vb_sync[2]) begin
      vbus_change_flag <= 1'b1;
    end else if (i_wr && i_addr == usbbsc_pkg::REG_CHG_FLAGS
                 && !i_wdata[usbbsc_pkg::POS_VCHG]) begin
      vbus_change_flag <= 1'b0;
    end
  end

  // Bus reset and idle timers; frozen clocks stop both
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !enabled || frozen) begin
      se0_cnt <= 7'h00;
      idle_cnt <= 24'h000000;
      line_q <= usbbsc_pkg::LINE_J;
    end else begin
      line_q <= line;
      if (line == usbbsc_pkg::LINE_SE0) begin
        if (se0_cnt != 7'(usbbsc_pkg::BUS_RST_CYC)) se0_cnt <= se0_cnt + 7'h01;
      end else begin
        se0_cnt <= 7'h00;
      end
      if (line != usbbsc_pkg::LINE_J || line != line_q) idle_cnt <= 24'h000000;
      else if (idle_cnt != 24'(usbbsc_pkg::SUSP_CYC)) idle_cnt <= idle_cnt + 24'h000001;
    end
  end

  // One pulse as the SE0 count reaches the bus reset length
  assign bus_reset_now = (line == usbbsc_pkg::LINE_SE0)
                         && (se0_cnt == 7'(usbbsc_pkg::BUS_RST_CYC - 1));

  // Device control and flags; disable acts as a controller reset
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !enabled) begin
      detach <= 1'b1;
      low_speed <= 1'b0;
      cpu_reset_on_bus_reset <= 1'b0;
      suspend_flag <= 1'b0;
      wake_flag <= 1'b0;
      bus_reset_flag <= 1'b0;
      wake_irq_en <= 1'b0;
      o_full_speed <= 1'b1;
    end else begin
      if (i_wr && i_addr == usbbsc_pkg::REG_DEV_CTRL) begin
        detach <= i_wdata[usbbsc_pkg::POS_DETACH];
        low_speed <= i_wdata[usbbsc_pkg::POS_LOWSPD];
        cpu_reset_on_bus_reset <= i_wdata[usbbsc_pkg::POS_CPURST];
        wake_irq_en <= i_wdata[usbbsc_pkg::POS_WAKE_IE];
      end
      if (idle_cnt == 24'(usbbsc_pkg::SUSP_CYC - 1)) begin
        suspend_flag <= 1'b1;
        wake_flag <= 1'b0;
        o_full_speed <= 1'b1;
      end else begin
        // Wake detection uses the raw line so it still works while frozen
        if ((line != usbbsc_pkg::LINE_J) && !detach) begin
          wake_flag <= 1'b1;
          suspend_flag <= 1'b0;
        end else if (wr_ctrl_hit) begin
          if (!i_wdata[usbbsc_pkg::POS_WAKE]) wake_flag <= 1'b0;
          if (!i_wdata[usbbsc_pkg::POS_SUSP]) suspend_flag <= 1'b0;
        end
        o_full_speed <= !low_speed;
      end
      if (bus_reset_now) bus_reset_flag <= 1'b1;
      else if (wr_ctrl_hit && !i_wdata[usbbsc_pkg::POS_EORST]) bus_reset_flag <= 1'b0;
    end
  end

  // Address: valid bit cleared by power-up, bus reset and disable
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !enabled || bus_reset_now) begin
      device_address_field <= 7'h00;
      address_valid <= 1'b0;
    end else if (i_wr && i_addr == usbbsc_pkg::REG_ADDR) begin
      device_address_field <= i_wdata[6:0];
      address_valid <= i_wdata[usbbsc_pkg::POS_ADDR_VALID];
    end
  end

  // Endpoint select
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !enabled) endpoint_select <= 3'h0;
    else if (i_wr && i_addr == usbbsc_pkg::REG_EP_NUM) endpoint_select <= i_wdata[2:0];
  end

  // Per-endpoint configuration; bus reset disables all but endpoint 0's config
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !enabled) begin
      ep_en <= '0;
      ep_memory_reserve <= '0;
      ep_cfg_ok <= '0;
      ep_toggle <= '0;
      ep_rst_pulse <= '0;
      for (int i = 0; i < usbbsc_pkg::NUM_EP; i++) begin
        ep_size[i] <= 3'h0;
        ep_bank[i] <= 1'b0;
      end
    end else begin
      ep_rst_pulse <= '0;
      ep_toggle <= ep_toggle ^ (i_ep_toggle_flip & ep_en);
      if (i_wr && i_addr == usbbsc_pkg::REG_EP_RESET) begin
        ep_rst_pulse <= i_wdata[usbbsc_pkg::NUM_EP-1:0];
      end
      if (i_wr && i_addr == usbbsc_pkg::REG_EP_CFG && endpoint_select < 3'h7) begin
        ep_en[endpoint_select] <= i_wdata[usbbsc_pkg::POS_EP_EN];
        ep_memory_reserve[endpoint_select] <= i_wdata[usbbsc_pkg::POS_EP_MEMORY_RESERVE];
        ep_size[endpoint_select] <= i_wdata[usbbsc_pkg::POS_EP_SIZE +: 3];
        ep_bank[endpoint_select] <= i_wdata[usbbsc_pkg::POS_EP_BANK];
        // Size check against the shared memory
        ep_cfg_ok[endpoint_select] <= i_wdata[usbbsc_pkg::POS_EP_EN]
          && i_wdata[usbbsc_pkg::POS_EP_MEMORY_RESERVE]
          && (ep_bytes(i_wdata[usbbsc_pkg::POS_EP_SIZE +: 3], i_wdata[usbbsc_pkg::POS_EP_BANK])
              <= usbbsc_pkg::DPRAM_BYTES);
        if (!i_wdata[usbbsc_pkg::POS_EP_EN]) begin
          ep_toggle[endpoint_select] <= 1'b0;
          ep_rst_pulse[endpoint_select] <= 1'b1;
        end else if (i_wdata[usbbsc_pkg::POS_EP_TOGGLE_CLEAR_CMD]) begin
          ep_toggle[endpoint_select] <= 1'b0;
        end
      end
      if (bus_reset_now) begin
        ep_en <= '0;
        ep_en[0] <= ep_en[0];
      end
    end
  end

  // Endpoint side outputs: held in reset while disabled
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_ep_reset <= '1;
      o_ep_ack_ok <= '0;
      o_match_addr <= 7'h00;
    end else begin
      o_ep_reset <= ep_rst_pulse | ~ep_en | {usbbsc_pkg::NUM_EP{!enabled}};
      o_ep_ack_ok <= ep_en & ep_cfg_ok;
      o_match_addr <= address_valid ? device_address_field : 7'h00;
    end
  end

  // Pad, clock and pull-up controls
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_regulator_on <= 1'b0;
      o_vbus_pad_on <= 1'b0;
      o_xcvr_on <= 1'b0;
      o_clk_run <= 1'b0;
      o_pad_active <= 1'b0;
      o_pullup_dp <= 1'b0;
      o_pullup_dm <= 1'b0;
      o_vbus_irq <= 1'b0;
      o_cpu_reset <= 1'b0;
    end else begin
      o_regulator_on <= pad_regulator_ctrl[usbbsc_pkg::POS_REG_EN];
      o_vbus_pad_on <= controller_ctrl[usbbsc_pkg::POS_VPAD];
      o_xcvr_on <= enabled;
      o_clk_run <= enabled && !frozen;
      o_pad_active <= enabled && !detach && !suspend_flag;
      // Pull-up needs attach and VBUS present
      o_pullup_dp <= enabled && !detach && vbus_state && !low_speed;
      o_pullup_dm <= enabled && !detach && vbus_state && low_speed;
      o_vbus_irq <= vbus_change_flag && controller_ctrl[usbbsc_pkg::POS_VIRQ];
      o_cpu_reset <= bus_reset_now && cpu_reset_on_bus_reset;
    end
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
    end else if (!i_rd) begin
      o_rdata <= 8'h00;
    end else if (i_addr == usbbsc_pkg::REG_PAD_REG_CTRL) begin
      o_rdata <= pad_regulator_ctrl;
    end else if (i_addr == usbbsc_pkg::REG_CTRL) begin
      o_rdata <= controller_ctrl;
    end else if (i_addr == usbbsc_pkg::REG_STATUS) begin
      o_rdata <= usbbsc_pkg::LEGACY_ONE | {7'h00, vbus_state};
    end else if (i_addr == usbbsc_pkg::REG_CHG_FLAGS) begin
      o_rdata <= {7'h00, vbus_change_flag};
    end else if (i_addr == usbbsc_pkg::REG_DEV_CTRL) begin
      o_rdata <= {3'h0, wake_irq_en, cpu_reset_on_bus_reset, low_speed, 1'b0, detach};
    end else if (i_addr == usbbsc_pkg::REG_DEV_FLAGS) begin
      o_rdata <= {3'h0, wake_flag, bus_reset_flag, 2'h0, suspend_flag};
    end else if (i_addr == usbbsc_pkg::REG_EP_NUM) begin
      o_rdata <= {5'h00, endpoint_select};
    end else if (i_addr == usbbsc_pkg::REG_EP_CFG && endpoint_select < 3'h7) begin
      o_rdata <= {1'b0, ep_size[endpoint_select], 1'b0, ep_bank[endpoint_select],
                  ep_memory_reserve[endpoint_select], ep_en[endpoint_select]};
    end else if (i_addr == usbbsc_pkg::REG_EP_STAT && endpoint_select < 3'h7) begin
      o_rdata <= {ep_cfg_ok[endpoint_select], 5'h00, ep_toggle[endpoint_select], 1'b0};
    end else if (i_addr == usbbsc_pkg::REG_ADDR) begin
      o_rdata <= {address_valid, device_address_field};
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // Checks: outputs are registered, so each consequent on an output looks one cycle after its cause
  a_vbus_flag_set: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $changed(vbus_state) |-> vbus_change_flag)
    else $error("vbus change not flagged");
  a_pullup_needs_vbus: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (o_pullup_dp || o_pullup_dm) |-> $past(vbus_state))
    else $error("pullup without vbus");
  a_status_legacy: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $past(i_rd && i_addr == usbbsc_pkg::REG_STATUS) |-> o_rdata[7:1] == 7'h01)
    else $error("status bits wrong");
  a_addr_default: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !address_valid |=> o_match_addr == 7'h00)
    else $error("addr not zero");
  a_bus_rst_cpu: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    bus_reset_now && cpu_reset_on_bus_reset && enabled |=> o_cpu_reset && o_xcvr_on)
    else $error("cpu reset missing");
  a_flags_exclusive: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !(suspend_flag && wake_flag))
    else $error("suspend and wake both set");
  a_freeze_clock: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    frozen |=> !o_clk_run)
    else $error("clock not frozen");
  a_irq_gate: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_vbus_irq |-> $past(controller_ctrl[usbbsc_pkg::POS_VIRQ]))
    else $error("irq ungated");
  // Attach and power controls
  a_no_vbus_pullup: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !vbus_state |=> !o_pullup_dp && !o_pullup_dm)
    else $error("pullup while vbus absent");
  a_detach_pullup: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    detach |=> !o_pullup_dp && !o_pullup_dm)
    else $error("pullup while detached");
  a_regulator_follow: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_regulator_on == $past(pad_regulator_ctrl[usbbsc_pkg::POS_REG_EN]))
    else $error("regulator enable not followed");
  a_disable_resets: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !enabled |=> !o_xcvr_on && !o_clk_run && (o_ep_reset == '1))
    else $error("disabled controller still running");
  // Endpoint side and suspend entry
  a_ep_rst_pulse: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (ep_rst_pulse != '0) |=> (o_ep_reset & $past(ep_rst_pulse)) == $past(ep_rst_pulse))
    else $error("endpoint reset not shown");
  a_ack_needs_cfg: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (o_ep_ack_ok & ~$past(ep_en & ep_cfg_ok)) == '0)
    else $error("ack without accepted config");
  a_bus_rst_ep: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    bus_reset_now |=> (ep_en[usbbsc_pkg::NUM_EP-1:1] == '0) && !address_valid)
    else $error("bus reset left endpoints on");
  a_susp_full_speed: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    enabled && (idle_cnt == 24'(usbbsc_pkg::SUSP_CYC - 1))
    |=> suspend_flag && !wake_flag && o_full_speed)
    else $error("suspend entry wrong");
endmodule // usbbsc_top

/* hw/usbbsc_pkg.sv */
// Package: register map, field positions, reset values and timing counts for bus-state control
package usbbsc_pkg;
  // Register offsets
  localparam logic [3:0] REG_PAD_REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_CHG_FLAGS = 4'h3;
  localparam logic [3:0] REG_DEV_CTRL = 4'h4;
  localparam logic [3:0] REG_DEV_FLAGS = 4'h5;
  localparam logic [3:0] REG_EP_NUM = 4'h6;
  localparam logic [3:0] REG_EP_RESET = 4'h7;
  localparam logic [3:0] REG_EP_CFG = 4'h8;
  localparam logic [3:0] REG_EP_STAT = 4'h9;
  localparam logic [3:0] REG_ADDR = 4'hA;
  // Field positions
  localparam int POS_REG_EN = 0;
  localparam int POS_CTRL_EN = 7;
  localparam int POS_FRZ = 5;
  localparam int POS_VPAD = 4;
  localparam int POS_VIRQ = 0;
  localparam int POS_VBUS = 0;
  localparam int POS_LEGACY = 1;
  localparam int POS_VCHG = 0;
  localparam int POS_DETACH = 0;
  localparam int POS_LOWSPD = 2;
  localparam int POS_CPURST = 3;
  localparam int POS_SUSP = 0;
  localparam int POS_WAKE = 4;
  localparam int POS_EORST = 3;
  localparam int POS_WAKE_IE = 4;
  localparam int POS_EP_EN = 0;
  localparam int POS_EP_TOGGLE_CLEAR_CMD = 3;
  localparam int POS_EP_SIZE = 4;
  localparam int POS_EP_BANK = 2;
  localparam int POS_EP_MEMORY_RESERVE = 1;
  localparam int POS_CFG_OK = 7;
  localparam int POS_TOGGLE = 1;
  localparam int POS_ADDR_VALID = 7;
  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h20;
  localparam logic [7:0] RST_DEV_CTRL = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] LEGACY_ONE = 8'h02;
  // Endpoint count and memory
  localparam int NUM_EP = 7;
  localparam logic [10:0] DPRAM_BYTES = 11'h340;
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int BUS_RST_NS = 2500;
  localparam int BUS_RST_CYC = (BUS_RST_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SUSP_MS = 3;
  localparam int SUSP_CYC = SUSP_MS * (CLK_HZ / 1000);
  // Line states
  typedef enum logic [2:0] {
    LINE_J = 3'b001,
    LINE_SE0 = 3'b010,
    LINE_K = 3'b100
  } usbbsc_line_e;
  // Pins from the pad, grouped
  typedef struct packed {
    logic vbus_valid;
    logic dp;
    logic dm;
  } usbbsc_pads_s;
endpackage

/* bench/usbbsc_host_model.sv */
// USB host model: drives VBUS and the line state seen by the device pads
`timescale 1ns/10ps
module usbbsc_host_model (
  // Clock
  input wire logic i_clk,
  // Device pull-ups
  input wire logic i_pullup_dp,
  input wire logic i_pullup_dm,
  // Pads
  output usbbsc_pkg::usbbsc_pads_s o_pads
);
  logic vbus = 1'b0;
  usbbsc_pkg::usbbsc_line_e line = usbbsc_pkg::LINE_J;
  logic dp_lvl;
  logic dm_lvl;
  // Released lines follow the device pull-ups against our pull-downs, so no stale level
  assign dp_lvl = (line == usbbsc_pkg::LINE_J) ? i_pullup_dp : 1'b0;
  assign dm_lvl = (line == usbbsc_pkg::LINE_K) ? 1'b1 :
                  ((line == usbbsc_pkg::LINE_J) ? i_pullup_dm : 1'b0);
  assign o_pads = {vbus, dp_lvl, dm_lvl};
  // Plug or unplug the cable
  task automatic set_vbus(input logic v);
    @(posedge i_clk);
    vbus <= v;
  endtask
  // Drive a line state for n cycles, then release the lines
  task automatic drive(input usbbsc_pkg::usbbsc_line_e l, input int n);
    @(posedge i_clk);
    line <= l;
    repeat (n) @(posedge i_clk);
    line <= usbbsc_pkg::LINE_J;
  endtask
endmodule // usbbsc_host_model

/* bench/usbbsc_top_test.sv */
// Self-checking bench for the USB bus-state control block
`timescale 1ns/10ps
module usbbsc_top_test;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [usbbsc_pkg::NUM_EP-1:0] i_ep_toggle_flip = '0;
  usbbsc_pkg::usbbsc_pads_s i_pads;
  logic [7:0] o_rdata;
  logic [usbbsc_pkg::NUM_EP-1:0] o_ep_reset, o_ep_ack_ok;
  logic [6:0] o_match_addr;
  logic o_regulator_on, o_vbus_pad_on, o_xcvr_on, o_clk_run, o_pad_active;
  logic o_pullup_dp, o_pullup_dm, o_full_speed, o_vbus_irq, o_cpu_reset;
  logic [15:0] note_q[$];
  logic [15:0] note;
  logic rd_d = 1'b0;
  logic [7:0] lfsr = 8'h07;
  int err_count = 0;
  int checks_done = 0;
  int cpu_pulses = 0;

  usbbsc_top usbbsc_top_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pads(i_pads),
    .i_ep_toggle_flip(i_ep_toggle_flip), .o_ep_reset(o_ep_reset),
    .o_ep_ack_ok(o_ep_ack_ok), .o_match_addr(o_match_addr),
    .o_regulator_on(o_regulator_on), .o_vbus_pad_on(o_vbus_pad_on),
    .o_xcvr_on(o_xcvr_on), .o_clk_run(o_clk_run), .o_pad_active(o_pad_active),
    .o_pullup_dp(o_pullup_dp), .o_pullup_dm(o_pullup_dm),
    .o_full_speed(o_full_speed), .o_vbus_irq(o_vbus_irq), .o_cpu_reset(o_cpu_reset));

  usbbsc_host_model usbbsc_host_model_i (.i_clk(i_clk), .i_pullup_dp(o_pullup_dp),
    .i_pullup_dm(o_pullup_dm), .o_pads(i_pads));

  // Clock at 20 MHz
  initial begin
    forever #25 i_clk = ~i_clk;
  end

  // Pseudo-random source for address values
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One-cycle write strobe; the leading edge keeps strobes from being assigned twice
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // One-cycle read strobe; the expected byte and its mask go on the queue
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge i_clk);
    note_q.push_back({m, e});
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask

  // Let n edges pass, then step clear of the edge so outputs are settled
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic test_done;
    if (err_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe; compare mid-cycle
  always @(posedge i_clk) begin
    rd_d <= i_rd;
  end
  always @(negedge i_clk) begin
    if (rd_d) begin
      note = note_q.pop_front();
      chk("rdata", note[7:0], o_rdata & note[15:8]);
    end
    if (o_cpu_reset === 1'b1) begin
      cpu_pulses++;
    end
  end

  // Watchdog sized for the suspend wait plus margin
  initial begin
    repeat (80000) @(posedge i_clk);
    err_count++;
    test_done();
  end

  initial begin
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    idle(1);
    chk("ep_reset", 8'h7F, 8'(o_ep_reset));
    chk("pullups", 8'h00, 8'({o_pullup_dp, o_pullup_dm}));
    chk("clk_run", 8'h00, 8'(o_clk_run));
    rd(usbbsc_pkg::REG_CTRL, 8'hFF, usbbsc_pkg::RST_CTRL);
    rd(usbbsc_pkg::REG_STATUS, 8'hFF, usbbsc_pkg::LEGACY_ONE);
    rd(4'hF, 8'hFF, 8'h00);
    // VBUS pad and regulator with the controller still disabled
    wr(usbbsc_pkg::REG_CTRL, 8'h11);
    wr(usbbsc_pkg::REG_PAD_REG_CTRL, 8'h01);
    idle(3);
    chk("vbus_pad_on", 8'h01, 8'(o_vbus_pad_on));
    chk("regulator_on", 8'h01, 8'(o_regulator_on));
    rd(usbbsc_pkg::REG_PAD_REG_CTRL, 8'h01, 8'h01);
    // Plug in with the change interrupt enabled, then unplug with it masked
    usbbsc_host_model_i.set_vbus(1'b1);
    idle(6);
    rd(usbbsc_pkg::REG_STATUS, 8'hFF, usbbsc_pkg::LEGACY_ONE | 8'h01);
    rd(usbbsc_pkg::REG_CHG_FLAGS, 8'hFF, 8'h01);
    chk("vbus_irq", 8'h01, 8'(o_vbus_irq));
    wr(usbbsc_pkg::REG_CHG_FLAGS, 8'h00);
    idle(3);
    chk("vbus_irq", 8'h00, 8'(o_vbus_irq));
    rd(usbbsc_pkg::REG_CHG_FLAGS, 8'hFF, 8'h00);
    wr(usbbsc_pkg::REG_CTRL, 8'h10);
    usbbsc_host_model_i.set_vbus(1'b0);
    idle(6);
    rd(usbbsc_pkg::REG_CHG_FLAGS, 8'hFF, 8'h01);
    rd(usbbsc_pkg::REG_STATUS, 8'hFF, usbbsc_pkg::LEGACY_ONE);
    chk("vbus_irq", 8'h00, 8'(o_vbus_irq));
    usbbsc_host_model_i.set_vbus(1'b1);
    idle(6);
    wr(usbbsc_pkg::REG_CHG_FLAGS, 8'h00);
    // Enable the controller; detach still holds the pull-up off
    wr(usbbsc_pkg::REG_CTRL, 8'h90);
    idle(3);
    chk("xcvr_clk", 8'h03, 8'({o_xcvr_on, o_clk_run}));
    chk("pullup_dp", 8'h00, 8'(o_pullup_dp));
    rd(usbbsc_pkg::REG_DEV_CTRL, 8'hFF, usbbsc_pkg::RST_DEV_CTRL);
    wr(usbbsc_pkg::REG_DEV_CTRL, 8'h00);
    idle(3);
    chk("pullup_dp", 8'h01, 8'(o_pullup_dp));
    wr(usbbsc_pkg::REG_CTRL, 8'hB0);
    idle(3);
    chk("clk_run", 8'h00, 8'(o_clk_run));
    wr(usbbsc_pkg::REG_CTRL, 8'h90);
    // Short unplug: kept well under the bus-reset span
    usbbsc_host_model_i.set_vbus(1'b0);
    idle(6);
    chk("pullup_dp", 8'h00, 8'(o_pullup_dp));
    usbbsc_host_model_i.set_vbus(1'b1);
    idle(6);
    chk("pullup_dp", 8'h01, 8'(o_pullup_dp));
    // Address first, valid bit in a later write
    lfsr = lfsr_next(lfsr);
    wr(usbbsc_pkg::REG_ADDR, {1'b0, lfsr[6:0]});
    idle(3);
    chk("match_addr", 8'h00, 8'(o_match_addr));
    wr(usbbsc_pkg::REG_ADDR, {1'b1, lfsr[6:0]});
    idle(3);
    chk("match_addr", 8'(lfsr[6:0]), 8'(o_match_addr));
    // Endpoint 1: enable, toggle, reset, disable, re-enable
    wr(usbbsc_pkg::REG_EP_NUM, 8'h01);
    wr(usbbsc_pkg::REG_EP_CFG, 8'h03);
    idle(3);
    chk("ep_ack_ok", 8'h02, 8'(o_ep_ack_ok));
    chk("ep_reset", 8'h7D, 8'(o_ep_reset));
    @(posedge i_clk);
    i_ep_toggle_flip <= 7'h02;
    @(posedge i_clk);
    i_ep_toggle_flip <= 7'h00;
    rd(usbbsc_pkg::REG_EP_STAT, 8'h82, 8'h82);
    wr(usbbsc_pkg::REG_EP_RESET, 8'h02);
    idle(1);
    chk("ep_reset", 8'h7F, 8'(o_ep_reset));
    idle(2);
    chk("ep_reset", 8'h7D, 8'(o_ep_reset));
    rd(usbbsc_pkg::REG_EP_STAT, 8'h82, 8'h82);
    chk("ep_ack_ok", 8'h02, 8'(o_ep_ack_ok));
    wr(usbbsc_pkg::REG_EP_CFG, 8'h02);
    idle(3);
    chk("ep_reset", 8'h7F, 8'(o_ep_reset));
    rd(usbbsc_pkg::REG_EP_CFG, 8'h76, 8'h02);
    wr(usbbsc_pkg::REG_EP_CFG, 8'h03);
    idle(3);
    rd(usbbsc_pkg::REG_EP_STAT, 8'h82, 8'h80);
    // Endpoint 2 asks for 1024 bytes, more than the shared memory holds
    wr(usbbsc_pkg::REG_EP_NUM, 8'h02);
    wr(usbbsc_pkg::REG_EP_CFG, 8'h73);
    idle(3);
    chk("ep_ack_ok", 8'h02, 8'(o_ep_ack_ok));
    rd(usbbsc_pkg::REG_EP_STAT, 8'h80, 8'h00);
    rd(usbbsc_pkg::REG_EP_CFG, 8'h77, 8'h73);
    // Bus reset with the CPU-reset option set
    wr(usbbsc_pkg::REG_DEV_CTRL, 8'h08);
    usbbsc_host_model_i.drive(usbbsc_pkg::LINE_SE0, usbbsc_pkg::BUS_RST_CYC + 10);
    idle(8);
    chk("cpu_pulses", 8'h01, 8'(cpu_pulses));
    chk("attached", 8'h03, 8'({o_xcvr_on, o_pullup_dp}));
    chk("match_addr", 8'h00, 8'(o_match_addr));
    chk("ep_ack_ok", 8'h00, 8'(o_ep_ack_ok));
    // Wake, then suspend after idle, then wake again
    wr(usbbsc_pkg::REG_DEV_FLAGS, 8'h00);
    usbbsc_host_model_i.drive(usbbsc_pkg::LINE_K, 4);
    idle(8);
    rd(usbbsc_pkg::REG_DEV_FLAGS, 8'h11, 8'h10);
    idle(usbbsc_pkg::SUSP_CYC + 20);
    rd(usbbsc_pkg::REG_DEV_FLAGS, 8'h11, 8'h01);
    chk("pad_active", 8'h00, 8'(o_pad_active));
    chk("full_speed", 8'h01, 8'(o_full_speed));
    usbbsc_host_model_i.drive(usbbsc_pkg::LINE_K, 4);
    idle(8);
    rd(usbbsc_pkg::REG_DEV_FLAGS, 8'h11, 8'h10);
    chk("pad_active", 8'h01, 8'(o_pad_active));
    idle(3);
    test_done();
  end
endmodule // usbbsc_top_test
